// [rtl/aspt_pkg.sv]
/*
  Shared constants and carrier types for the second asynchronous serial port.
  Assumes one 40 MHz core clock and word-wide AHB-Lite register access.
*/
package aspt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] FLAGS_IDX  = 12'hf98;
  localparam logic [11:0] HOLD_IDX   = 12'hf9a;
  localparam logic [11:0] CTRL_A_IDX = 12'hf9c;
  localparam logic [11:0] CTRL_B_IDX = 12'hf9e;

  // Status bits 1 and 0 read as zero
  localparam logic [7:0] FLAGS_RESET  = 8'h0c;
  localparam logic [7:0] HOLD_RESET   = 8'h00;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;

  // Rate codes and sub-bit clock divisors
  localparam logic [2:0] RATE_TIMER = 3'h6;
  localparam logic [8:0] DIV_CODE_0 = 9'h00d;
  localparam logic [8:0] DIV_CODE_1 = 9'h01a;
  localparam logic [8:0] DIV_CODE_2 = 9'h034;
  localparam logic [8:0] DIV_CODE_3 = 9'h068;
  localparam logic [8:0] DIV_CODE_4 = 9'h0d0;
  localparam logic [8:0] DIV_CODE_5 = 9'h1a0;
  localparam logic [8:0] DIV_CODE_7 = 9'h060;

  // Receive noise filter lengths in core clock periods
  localparam logic [6:0] FILTER_SHORT  = 7'h1f;
  localparam logic [6:0] FILTER_MEDIUM = 7'h3f;
  localparam logic [6:0] FILTER_LONG   = 7'h7f;

  // Sub-bit tick positions
  localparam logic [3:0] RT_SAMPLE_A = 4'h7;
  localparam logic [3:0] RT_SAMPLE_B = 4'h8;
  localparam logic [3:0] RT_SAMPLE_C = 4'h9;
  localparam logic [3:0] RT_LAST     = 4'hf;

  // Frame bit indices: 0 start, 1..8 data, then parity and stops
  localparam logic [3:0] BIT_PARITY  = 4'h9;
  localparam logic [3:0] BIT_LAST_MIN = 4'h9;

  typedef struct packed {
    logic       txEnableBit;
    logic       rxEnableBit;
    logic       txStopLength;
    logic       parityEven;
    logic       parityEnable;
    logic [2:0] rateSelect;
  } aspt_ctrl_a_t;

  typedef struct packed {
    logic [2:0] unusedHigh;
    logic [1:0] rxFilterSelect;
    logic [1:0] unusedLow;
    logic       rxStopLength;
  } aspt_ctrl_b_t;

  typedef struct packed {
    logic       parityErrorFlag;
    logic       framingErrorFlag;
    logic       overrunFlag;
    logic       rxFullFlag;
    logic       txFinishedFlag;
    logic       txBufferEmptyFlag;
    logic [1:0] unused;
  } aspt_flags_t;

endpackage

// [rtl/aspt_uart.sv]
/*
  Second asynchronous serial port: AHB-Lite register slave, rate generator,
  receive noise filter, majority-vote receiver and framed transmitter.
  Assumes synchronous pins, a word-only AHB master and a one-cycle
  timer pulse on rateTimerPulse when the timer rate is chosen.
*/
// How it works
// - Frames are one low start bit, eight data bits, optional parity, high stops.
// - Parity enable switches parity on; parity type picks even or odd.
// - Transmitter sends one or two stop bits per transmit stop length.
// - Rate code 110 takes the timer pulse as the sixteen-times sub-bit clock.
// - Codes 000 to 101 divide the core clock by 13 doubling up to 416.
// - Idle receiver samples the input at each rate tick looking for low.
// - Each bit is sampled at sub-bit ticks seven, eight and nine.
// - Bit value is the level seen in two or more of three samples.
// - Accepted holding write clears buffer-empty and starts the frame.
// - Frame start sets buffer-empty and pulses the transmit interrupt.
// - Output pin stays high when disabled and until a byte is written.
// - Holding write without a prior status read is ignored.
// - At the last stop bit's ninth-tick sample, data loads the receive buffer, sets full, pulses interrupt.
// - Clearing receive enable waits for the current frame to finish.
// - Parity error set when computed parity differs from received parity bit.
// - Framing error set when any stop bit is sampled low.
// - Frame arriving with buffer still full sets overrun and is discarded.
// - Error and full flags clear on buffer read following a status read.
// - Receiver does not start new frames while overrun is set.
// - Overrun set after the status read survives the next buffer read.
// - Status holds flags in bits 7 to 2, reset value 0000 11 then zeros.
// - Receive and transmit holding registers share one address.
// - Rate and parity settings serve both transmitter and receiver.
// - Disabling waits for the current transfer; unsent buffered data is dropped.
// - Filter settings 01, 10, 11 reject input pulses under 31, 63 or 127 core clocks; 00 passes the pin straight through.
// - Receiver expects one or two stops per its own receive stop length.
`timescale 1ns/1ps
module aspt_uart
  import aspt_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Serial pins and timer rate input
  input  wire logic        serialInPin,
  output logic             serialOutPin,
  input  wire logic        rateTimerPulse,
  // Interrupt pulses to the system controller
  output logic             txIrq,
  output logic             rxIrq
);

  typedef enum logic {RX_IDLE, RX_FRAME} aspt_rx_state_t;
  typedef enum logic {TX_IDLE, TX_FRAME} aspt_tx_state_t;

  // Bus and register state
  aspt_ctrl_a_t ctrlA, next_ctrlA;
  aspt_ctrl_b_t ctrlB, next_ctrlB;
  aspt_flags_t  flags;
  logic [31:0]  next_hrdata;
  logic         wrPend, next_wrPend;
  logic [11:0]  wrIdx, next_wrIdx;
  logic         armed, next_armed;
  logic         armedOverrun, next_armedOverrun;
  logic         accept;
  logic         addrOk;
  logic [11:0]  addrIdx;
  logic         rdFlags;
  logic         rdHold;
  logic         wrHold;
  logic         clearRx;

  // Rate and filter state
  logic [8:0]   divCount, next_divCount;
  logic [8:0]   divLimit;
  logic         tick, next_tick;
  logic         rxLevel, next_rxLevel;
  logic [6:0]   fltCount, next_fltCount;
  logic [6:0]   fltLimit;

  // Receiver state
  aspt_rx_state_t rxState, next_rxState;
  logic [3:0]   rxRt, next_rxRt;
  logic [3:0]   rxBit, next_rxBit;
  logic [1:0]   votes, next_votes;
  logic [7:0]   rxShift, next_rxShift;
  logic         rxParity, next_rxParity;
  logic         stopBad, next_stopBad;
  logic [7:0]   rxHold, next_rxHold;
  logic         parity_error_flag, next_parity_error_flag;
  logic         framing_error_flag, next_framing_error_flag;
  logic         oerr, next_oerr;
  logic         full, next_full;
  logic         next_rxIrq;
  logic [3:0]   rxLastBit;
  logic [2:0]   voteSum;
  logic         bitVal;
  logic         expectParity;

  // Transmitter state
  aspt_tx_state_t txState, next_txState;
  logic [7:0]   txHold, next_txHold;
  logic         txPending, next_txPending;
  logic [7:0]   txShift, next_txShift;
  logic [3:0]   txBit, next_txBit;
  logic [3:0]   txRt, next_txRt;
  logic [3:0]   txLast, next_txLast;
  logic         txParBit, next_txParBit;
  logic         tx_buffer_empty_flag, next_tx_buffer_empty_flag;
  logic         tx_finished_flag, next_tx_finished_flag;
  logic         next_txIrq;
  logic         next_serialOutPin;

  assign flags = '{parityErrorFlag: parity_error_flag, framingErrorFlag: framing_error_flag, overrunFlag: oerr,
                   rxFullFlag: full, txFinishedFlag: tx_finished_flag, txBufferEmptyFlag: tx_buffer_empty_flag,
                   unused: 2'h0};

  // Zero-wait slave; every transfer answers OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb
  begin
    addrIdx = haddr[13:2];
    addrOk  = (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'h0);
    accept  = hsel && htrans[1] && hready && addrOk;
    rdFlags = accept && !hwrite && (addrIdx == FLAGS_IDX);
    rdHold  = accept && !hwrite && (addrIdx == HOLD_IDX);
    wrHold  = wrPend && (wrIdx == HOLD_IDX);
    clearRx = rdHold && armed;
    next_wrPend = accept && hwrite;
    next_wrIdx  = addrIdx;
    next_hrdata = 32'h00000000;
    if (accept && !hwrite)
    begin
      case (addrIdx)
        FLAGS_IDX:  next_hrdata = {24'h000000, flags};
        HOLD_IDX:   next_hrdata = {24'h000000, rxHold};
        CTRL_A_IDX: next_hrdata = {24'h000000, ctrlA};
        CTRL_B_IDX: next_hrdata = {24'h000000, ctrlB};
        default:    next_hrdata = 32'h00000000;
      endcase
    end
    next_ctrlA = ctrlA;
    next_ctrlB = ctrlB;
    if (wrPend && (wrIdx == CTRL_A_IDX))
    begin
      next_ctrlA = hwdata[7:0];
    end
    if (wrPend && (wrIdx == CTRL_B_IDX))
    begin
      next_ctrlB = hwdata[7:0];
    end
    // A status read arms one following holding access
    next_armed        = armed;
    next_armedOverrun = armedOverrun;
    if (rdFlags)
    begin
      next_armed        = 1'b1;
      next_armedOverrun = oerr;
    end
    else if (rdHold || wrHold)
    begin
      next_armed        = 1'b0;
      next_armedOverrun = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hrdata       <= 32'h00000000;
      wrPend       <= 1'b0;
      wrIdx        <= 12'h000;
      ctrlA        <= CTRL_A_RESET;
      ctrlB        <= CTRL_B_RESET;
      armed        <= 1'b0;
      armedOverrun <= 1'b0;
    end
    else
    begin
      hrdata       <= next_hrdata;
      wrPend       <= next_wrPend;
      wrIdx        <= next_wrIdx;
      ctrlA        <= next_ctrlA;
      ctrlB        <= next_ctrlB;
      armed        <= next_armed;
      armedOverrun <= next_armedOverrun;
    end
  end

  // One tick source feeds both directions
  always_comb
  begin
    case (ctrlA.rateSelect)
      3'h0:    divLimit = DIV_CODE_0;
      3'h1:    divLimit = DIV_CODE_1;
      3'h2:    divLimit = DIV_CODE_2;
      3'h3:    divLimit = DIV_CODE_3;
      3'h4:    divLimit = DIV_CODE_4;
      3'h5:    divLimit = DIV_CODE_5;
      default: divLimit = DIV_CODE_7;
    endcase
    case (ctrlB.rxFilterSelect)
      2'h1:    fltLimit = FILTER_SHORT;
      2'h2:    fltLimit = FILTER_MEDIUM;
      default: fltLimit = FILTER_LONG;
    endcase
    next_divCount = divCount + 9'h001;
    next_tick     = 1'b0;
    if (ctrlA.rateSelect == RATE_TIMER)
    begin
      next_divCount = 9'h000;
      next_tick     = rateTimerPulse;
    end
    else if (divCount >= divLimit - 9'h001)
    begin
      next_divCount = 9'h000;
      next_tick     = 1'b1;
    end
    // Level must hold a full filter span before it is believed
    next_rxLevel  = rxLevel;
    next_fltCount = 7'h00;
    if (ctrlB.rxFilterSelect == 2'h0)
    begin
      next_rxLevel = serialInPin;
    end
    else if (serialInPin != rxLevel)
    begin
      if (fltCount >= fltLimit - 7'h01)
      begin
        next_rxLevel = serialInPin;
      end
      else
      begin
        next_fltCount = fltCount + 7'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      divCount <= 9'h000;
      tick     <= 1'b0;
      rxLevel  <= 1'b1;
      fltCount <= 7'h00;
    end
    else
    begin
      divCount <= next_divCount;
      tick     <= next_tick;
      rxLevel  <= next_rxLevel;
      fltCount <= next_fltCount;
    end
  end

  // Receiver
  always_comb
  begin
    rxLastBit    = BIT_LAST_MIN + {3'h0, ctrlA.parityEnable} + {3'h0, ctrlB.rxStopLength};
    voteSum      = {1'b0, votes} + {2'h0, rxLevel};
    bitVal       = voteSum >= 3'h2;
    expectParity = ctrlA.parityEven ? ^rxShift : ~^rxShift;
    next_rxState  = rxState;
    next_rxRt     = rxRt;
    next_rxBit    = rxBit;
    next_votes    = votes;
    next_rxShift  = rxShift;
    next_rxParity = rxParity;
    next_stopBad  = stopBad;
    next_rxHold   = rxHold;
    next_rxIrq    = 1'b0;
    next_parity_error_flag     = clearRx ? 1'b0 : parity_error_flag;
    next_framing_error_flag     = clearRx ? 1'b0 : framing_error_flag;
    next_full     = clearRx ? 1'b0 : full;
    next_oerr     = (clearRx && armedOverrun) ? 1'b0 : oerr;
    case (rxState)
      RX_IDLE:
      begin
        // Enable is looked at only between frames
        if (tick && !rxLevel && ctrlA.rxEnableBit && !oerr)
        begin
          next_rxState = RX_FRAME;
          next_rxRt    = 4'h1;
          next_rxBit   = 4'h0;
          next_stopBad = 1'b0;
        end
      end
      RX_FRAME:
      begin
        if (tick)
        begin
          next_rxRt = rxRt + 4'h1;
          if (rxRt == RT_LAST)
          begin
            next_rxBit = rxBit + 4'h1;
          end
          if (rxRt == RT_SAMPLE_A)
          begin
            next_votes = {1'b0, rxLevel};
          end
          else if (rxRt == RT_SAMPLE_B)
          begin
            next_votes = votes + {1'b0, rxLevel};
          end
          else if (rxRt == RT_SAMPLE_C)
          begin
            if (rxBit == 4'h0)
            begin
              // Glitch shorter than half a bit is not a start
              if (bitVal)
              begin
                next_rxState = RX_IDLE;
              end
            end
            else if (rxBit <= 4'h8)
            begin
              next_rxShift = {bitVal, rxShift[7:1]};
            end
            else if ((rxBit == BIT_PARITY) && ctrlA.parityEnable)
            begin
              next_rxParity = bitVal;
            end
            else if (!bitVal)
            begin
              next_stopBad = 1'b1;
            end
            if (rxBit == rxLastBit)
            begin
              next_rxState = RX_IDLE;
              if (full && !clearRx)
              begin
                next_oerr = 1'b1;
              end
              else
              begin
                next_rxHold = rxShift;
                next_full   = 1'b1;
                next_rxIrq  = 1'b1;
                next_parity_error_flag   = ctrlA.parityEnable && (rxParity != expectParity);
                next_framing_error_flag   = stopBad || !bitVal;
              end
            end
          end
        end
      end
      default: next_rxState = RX_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxState  <= RX_IDLE;
      rxRt     <= 4'h0;
      rxBit    <= 4'h0;
      votes    <= 2'h0;
      rxShift  <= 8'h00;
      rxParity <= 1'b0;
      stopBad  <= 1'b0;
      rxHold   <= HOLD_RESET;
      parity_error_flag     <= FLAGS_RESET[7];
      framing_error_flag     <= FLAGS_RESET[6];
      oerr     <= FLAGS_RESET[5];
      full     <= FLAGS_RESET[4];
      rxIrq    <= 1'b0;
    end
    else
    begin
      rxState  <= next_rxState;
      rxRt     <= next_rxRt;
      rxBit    <= next_rxBit;
      votes    <= next_votes;
      rxShift  <= next_rxShift;
      rxParity <= next_rxParity;
      stopBad  <= next_stopBad;
      rxHold   <= next_rxHold;
      parity_error_flag     <= next_parity_error_flag;
      framing_error_flag     <= next_framing_error_flag;
      oerr     <= next_oerr;
      full     <= next_full;
      rxIrq    <= next_rxIrq;
    end
  end

  // Transmitter
  always_comb
  begin
    next_txState   = txState;
    next_txHold    = txHold;
    next_txPending = txPending;
    next_txShift   = txShift;
    next_txBit     = txBit;
    next_txRt      = txRt;
    next_txLast    = txLast;
    next_txParBit  = txParBit;
    next_tx_buffer_empty_flag      = tx_buffer_empty_flag;
    next_tx_finished_flag      = tx_finished_flag;
    next_txIrq     = 1'b0;
    case (txState)
      TX_IDLE:
      begin
        if (txPending && ctrlA.txEnableBit)
        begin
          next_txState   = TX_FRAME;
          next_txShift   = txHold;
          next_txPending = 1'b0;
          next_txBit     = 4'h0;
          next_txRt      = 4'h0;
          next_txLast    = BIT_LAST_MIN + {3'h0, ctrlA.parityEnable} + {3'h0, ctrlA.txStopLength};
          next_txParBit  = ctrlA.parityEven ? ^txHold : ~^txHold;
          next_tx_buffer_empty_flag      = 1'b1;
          next_tx_finished_flag      = 1'b0;
          next_txIrq     = 1'b1;
        end
        else if (!ctrlA.txEnableBit && txPending)
        begin
          next_txPending = 1'b0;
          next_tx_buffer_empty_flag      = 1'b1;
        end
      end
      TX_FRAME:
      begin
        // Disable is not checked here so the frame always completes
        if (tick)
        begin
          next_txRt = txRt + 4'h1;
          if (txRt == RT_LAST)
          begin
            next_txBit = txBit + 4'h1;
            if ((txBit >= 4'h1) && (txBit <= 4'h8))
            begin
              next_txShift = {1'b0, txShift[7:1]};
            end
            if (txBit == txLast)
            begin
              next_txState = TX_IDLE;
              next_tx_finished_flag    = !txPending;
            end
          end
        end
      end
      default: next_txState = TX_IDLE;
    endcase
    // Unarmed writes fall on the floor
    if (wrHold && armed)
    begin
      next_txHold    = hwdata[7:0];
      next_txPending = 1'b1;
      next_tx_buffer_empty_flag      = 1'b0;
    end
    next_serialOutPin = 1'b1;
    if (txState == TX_FRAME)
    begin
      if (txBit == 4'h0)
      begin
        next_serialOutPin = 1'b0;
      end
      else if (txBit <= 4'h8)
      begin
        next_serialOutPin = txShift[0];
      end
      else if ((txBit == BIT_PARITY) && ctrlA.parityEnable)
      begin
        next_serialOutPin = txParBit;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txState      <= TX_IDLE;
      txHold       <= HOLD_RESET;
      txPending    <= 1'b0;
      txShift      <= 8'h00;
      txBit        <= 4'h0;
      txRt         <= 4'h0;
      txLast       <= BIT_LAST_MIN;
      txParBit     <= 1'b0;
      tx_buffer_empty_flag         <= FLAGS_RESET[2];
      tx_finished_flag         <= FLAGS_RESET[3];
      txIrq        <= 1'b0;
      serialOutPin <= 1'b1;
    end
    else
    begin
      txState      <= next_txState;
      txHold       <= next_txHold;
      txPending    <= next_txPending;
      txShift      <= next_txShift;
      txBit        <= next_txBit;
      txRt         <= next_txRt;
      txLast       <= next_txLast;
      txParBit     <= next_txParBit;
      tx_buffer_empty_flag         <= next_tx_buffer_empty_flag;
      tx_finished_flag         <= next_tx_finished_flag;
      txIrq        <= next_txIrq;
      serialOutPin <= next_serialOutPin;
    end
  end

endmodule

// [tb/aspt_uart_chk.sv]
/*
  Bound property checker for the serial port's bus and pin behaviour.
  Assumes one clock domain and hready tied to hreadyout.
*/
`timescale 1ns/1ps
module aspt_uart_chk
  import aspt_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Pins
  input wire logic        serialInPin,
  input wire logic        serialOutPin,
  input wire logic        txIrq,
  input wire logic        rxIrq
);
  logic xfer, stRd, holdAcc, holdWr, armed, wrSeen, quiet, sentAny;
  assign xfer    = hsel && htrans[1] && hready;
  assign stRd    = xfer && !hwrite && haddr == {18'h0, FLAGS_IDX, 2'h0};
  assign holdAcc = xfer && haddr == {18'h0, HOLD_IDX, 2'h0};
  assign holdWr  = holdAcc && hwrite;
  // Quiet means no frame could have moved a flag yet
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      {armed, wrSeen, sentAny, quiet} <= 4'h1;
    else
    begin
      armed   <= stRd || (armed && !holdAcc);
      wrSeen  <= wrSeen || holdWr;
      sentAny <= sentAny || txIrq;
      quiet   <= quiet && !holdWr && serialInPin;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  a_idle_high: assert property (!sentAny && !txIrq |-> serialOutPin)
    else $error("tx pin left idle level");
  a_start_low: assert property (txIrq |=> !serialOutPin)
    else $error("no start bit at frame start");
  a_start_holds: assert property ($fell(serialOutPin) |=> !serialOutPin [*8])
    else $error("start bit too short");
  a_tx_pulse: assert property (txIrq |=> !txIrq)
    else $error("tx interrupt longer than a cycle");
  a_rx_pulse: assert property (rxIrq |=> !rxIrq)
    else $error("rx interrupt longer than a cycle");
  a_read_idle: assert property (!$past(xfer && !hwrite) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_status_shape: assert property ($past(stRd) |-> hrdata[1:0] == 2'h0 && hrdata[31:8] == 24'h0)
    else $error("status spare bits set");
  a_reset_flags: assert property ($past(stRd && quiet) |-> hrdata == {24'h0, FLAGS_RESET})
    else $error("status differs from reset value");
  a_zero_wait: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");
  a_unarmed_write: assert property (holdWr && !armed && !wrSeen |=> !txIrq [*6])
    else $error("unarmed write started a frame");
  c_tx: cover property (txIrq);
  c_rx: cover property (rxIrq);
  c_unarmed: cover property (holdWr && !armed);
endmodule

bind aspt_uart aspt_uart_chk chk_u (.clock, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .serialInPin, .serialOutPin, .txIrq, .rxIrq);

// [tb/aspt_serial_peer.sv]
/*
  Remote serial node: drives frames into the port and decodes its output.
  Assumes bit lengths are given in core clock cycles.
*/
`timescale 1ns/1ps
module aspt_serial_peer
(
  // Clock
  input  wire logic clock,
  // Serial lines
  output logic      lineToDut,
  input  wire logic lineFromDut
);
  initial lineToDut = 1'b1;
  // Idle tail of one bit keeps a late start hunt from seeing low
  task automatic send(input logic [7:0] d, input logic p, input logic pOn, input logic badStop,
                      input int bitLen);
    logic [10:0] f;
    f = pOn ? {~badStop, p, d, 1'b0} : {1'b1, ~badStop, d, 1'b0};
    for (int i = 0; i < 12; i++)
    begin
      lineToDut <= i < 11 ? f[i] : 1'b1;
      repeat (bitLen) @(posedge clock);
    end
  endtask
  // Mid-bit sampling; positions past the stops read the idle level
  task automatic recv(input int bitLen, output logic [11:0] f, output logic ok);
    int n;
    n = 0;
    while (lineFromDut !== 1'b0 && n < 20000)
    begin
      @(posedge clock);
      n++;
    end
    ok = n < 20000;
    repeat (bitLen / 2) @(posedge clock);
    for (int i = 0; i < 12; i++)
    begin
      f[i] = lineFromDut;
      repeat (bitLen) @(posedge clock);
    end
  endtask
endmodule

// [tb/tb_aspt_uart.sv]
/*
  Self-checking bench for the second serial port.
  Assumes the checker binds itself and the peer owns the receive line.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module tb_aspt_uart
  import aspt_pkg::*;
;
  localparam int BITLEN = 16 * int'(DIV_CODE_0);
  localparam logic [7:0] TXCFG [4] = '{8'hb8, 8'h88, 8'h80, 8'ha6};
  logic        clock, reset_n, hsel, hwrite, hreadyout, hresp, rateTimerPulse;
  logic        serialInPin, serialOutPin, txIrq, rxIrq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          tick = 0;

  aspt_uart dut_u (.clock, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .serialInPin, .serialOutPin,
    .rateTimerPulse, .txIrq, .rxIrq);
  aspt_serial_peer peer_u (.clock, .lineToDut(serialInPin), .lineFromDut(serialOutPin));

  always #12.5 clock = ~clock;
  // Timer stand-in: one sub-bit tick every fourth cycle
  always @(posedge clock) tick <= (tick + 1) % 4;
  always @(posedge clock) rateTimerPulse <= tick == 3;

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic hang(input logic ok);
    if (!ok)
    begin
      num_errors++;
      finish_test();
    end
  endtask

  task automatic edgeRdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    hang(n < 64);
  endtask

  task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d, output logic [7:0] r);
    htrans <= 2'h2;
    haddr  <= {18'h0, i, 2'h0};
    hwrite <= w;
    edgeRdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    edgeRdy();
    r = hrdata[7:0];
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, i, d, r);
  endtask

  task automatic expRd(input logic [11:0] i, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, i, 8'h00, r);
    `CHK(r, e)
  endtask

  function automatic logic [11:0] frm(input logic [7:0] c, input logic [7:0] d);
    logic p;
    p = c[4] ? ^d : ~^d;
    return c[3] ? {2'b11, p, d, 1'b0} : {3'b111, d, 1'b0};
  endfunction

  task automatic t_regs();
    expRd(FLAGS_IDX, FLAGS_RESET);
    expRd(HOLD_IDX, 8'h00);
    wr(12'h010, 8'hff);
    expRd(12'h010, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_tx();
    logic [11:0] f;
    logic        ok;
    logic [7:0]  d;
    wr(CTRL_A_IDX, 8'h80);
    wr(HOLD_IDX, 8'h11);
    repeat (300) @(posedge clock);
    `CHK(serialOutPin, 1'b1)
    expRd(FLAGS_IDX, 8'h0c);
    for (int k = 0; k < 4; k++)
    begin
      d = 8'h3c ^ 8'(k);
      wr(CTRL_A_IDX, TXCFG[k]);
      fork
        begin
          wr(HOLD_IDX, d);
          // Frame start lands one cycle after the write
          repeat (2) @(posedge clock);
          expRd(FLAGS_IDX, 8'h04);
        end
        peer_u.recv(TXCFG[k][2:0] == RATE_TIMER ? 64 : BITLEN, f, ok);
      join
      hang(ok);
      `CHK(f, frm(TXCFG[k], d))
      repeat (2 * BITLEN) @(posedge clock);
      expRd(FLAGS_IDX, 8'h0c);
    end
    $display("test tx done");
  endtask

  task automatic t_rx();
    wr(CTRL_A_IDX, 8'h58);
    peer_u.send(8'ha7, ^8'ha7, 1'b1, 1'b0, BITLEN);
    expRd(FLAGS_IDX, 8'h1c);
    expRd(HOLD_IDX, 8'ha7);
    expRd(FLAGS_IDX, 8'h0c);
    peer_u.send(8'h33, ~^8'h33, 1'b1, 1'b1, BITLEN);
    expRd(FLAGS_IDX, 8'hdc);
    peer_u.send(8'h44, ^8'h44, 1'b1, 1'b0, BITLEN);
    expRd(FLAGS_IDX, 8'hfc);
    expRd(HOLD_IDX, 8'h33);
    expRd(FLAGS_IDX, 8'h0c);
    // Short filter and two stops; the idle tail serves as second stop
    wr(CTRL_B_IDX, 8'h09);
    peer_u.send(8'h5a, ^8'h5a, 1'b1, 1'b0, BITLEN);
    expRd(FLAGS_IDX, 8'h1c);
    expRd(HOLD_IDX, 8'h5a);
    $display("test rx done");
  endtask

  initial
  begin
    clock = 1'b0;
    reset_n = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_tx();
    t_rx();
    finish_test();
  end
endmodule
